/* File: verilog/scp_sysclk_gen.sv */
`include "scp_defs.svh"

module scp_sysclk_gen
(
    input wire logic clock, // 250 MHz sampling clock
    input wire logic rst, // async reset, active high
    input wire logic crystal_input, // crystal oscillator level
    input wire logic internal_clock_source, // on-chip oscillator level
    input wire logic direct_clock_input, // direct drive clock level
    input wire logic [1:0] clock_source_select, // 11 direct, 10 pll/presc
    input wire logic vco_bypass, // 1 selects prescaler with select 10
    input wire logic osc_source_internal, // 1 internal, 0 crystal
    input wire logic [`SCP_DIV_W-1:0] prescaler_divider_field, // factor-1
    output logic sys_clk_out, // generated system clock
    output scp_pkg::scp_cfg_s active_cfg, // configuration in force
    output logic clock_running // clock generated from a valid source
);

    scp_pkg::scp_state_e st_r;
    scp_pkg::scp_state_e st_nxt;
    scp_pkg::scp_cfg_s act_r;
    scp_pkg::scp_cfg_s act_nxt;
    scp_pkg::scp_cfg_s req;
    logic [`SCP_DIV_W-1:0] cnt_r;
    logic [`SCP_DIV_W-1:0] cnt_nxt;
    logic [`SCP_DIV_W-1:0] eff_div;
    logic sys_clk_r;
    logic sys_clk_nxt;
    logic running_r;
    logic src_level;
    logic src_rise;
    logic src_edge;

    assign req = {clock_source_select, vco_bypass, osc_source_internal,
                  prescaler_divider_field};

    scp_src_tap u_tap
    (
        .clock(clock),
        .rst(rst),
        .crystal_input(crystal_input),
        .internal_clock_source(internal_clock_source),
        .direct_clock_input(direct_clock_input),
        .cfg(act_r),
        .src_level(src_level),
        .src_rise(src_rise),
        .src_edge(src_edge)
    );

    assign eff_div = scp_pkg::scp_eff_div(act_r);
    wire act_ok = scp_pkg::scp_cfg_valid(act_r);
    wire pend = req != act_r;
    wire run = st_r == scp_pkg::SCP_RUN;
    // output toggles after factor source half-periods; factor one follows
    // every source edge, so the source duty cycle passes through
    wire at_limit = cnt_r == eff_div;
    wire step = run && act_ok && src_edge;
    wire tog = step && at_limit;
    // a new setting is taken where a full low phase has just ended, or at once from an unbuilt setting,
    // so no pulse is ever cut short; a stopped source delays the switch
    wire go_hold = run && ((!act_ok && pend) || (tog && !sys_clk_r && pend));
    wire reload = go_hold || (!run && pend);
    wire start = !run && !pend && act_ok && src_rise;
    wire leave_off = !run && !pend && !act_ok;

    assign act_nxt = reload ? req : act_r;
    assign st_nxt = go_hold ? scp_pkg::SCP_HOLD :
                    (start || leave_off) ? scp_pkg::SCP_RUN : st_r;
    assign sys_clk_nxt = start ? 1'h1 :
                         go_hold ? 1'h0 :
                         tog ? !sys_clk_r : sys_clk_r;
    assign cnt_nxt = (start || reload || tog) ? `SCP_DIV_RST :
                     step ? cnt_r + 10'h001 : cnt_r;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_r <= scp_pkg::SCP_RUN;
            act_r <= {`SCP_SEL_RST, `SCP_BYPASS_RST, `SCP_OSC_INT_RST,
                      `SCP_DIV_RST};
            cnt_r <= `SCP_DIV_RST;
            sys_clk_r <= 1'h0;
            running_r <= 1'h0;
        end
        else
        begin
            st_r <= st_nxt;
            act_r <= act_nxt;
            cnt_r <= cnt_nxt;
            sys_clk_r <= sys_clk_nxt;
            running_r <= (st_nxt == scp_pkg::SCP_RUN) &&
                         scp_pkg::scp_cfg_valid(act_nxt);
        end
    end

    assign sys_clk_out = sys_clk_r;
    assign active_cfg = act_r;
    assign clock_running = running_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_hold_low: assert property (st_r == scp_pkg::SCP_HOLD |-> !sys_clk_r)
        else $error("clock not parked low while waiting");
    a_cfg_on_low: assert property ($changed(act_r)
        |-> !sys_clk_r && $past(!sys_clk_r))
        else $error("setting changed outside low phase");
    a_fall_full_high: assert property ($fell(sys_clk_r)
        |-> $past(tog))
        else $error("high phase ended before its count");
    a_rise_cause: assert property ($rose(sys_clk_r)
        |-> $past(start || (tog && !pend)))
        else $error("clock rose without cause");
    a_off_low: assert property (!act_ok |-> !sys_clk_r && !clock_running)
        else $error("clock active in unbuilt mode");
    a_div1_fall: assert property (step && eff_div == `SCP_DIV_ONE &&
        sys_clk_r |=> !sys_clk_r)
        else $error("factor one did not follow falling source");
    a_div1_rise: assert property (step && eff_div == `SCP_DIV_ONE &&
        !sys_clk_r && !pend |=> sys_clk_r)
        else $error("factor one did not follow rising source");
    a_cnt_bound: assert property (cnt_r <= eff_div)
        else $error("prescaler count past its factor");
    a_hold_exit: assert property (st_r == scp_pkg::SCP_HOLD && !pend &&
        act_ok && src_rise |=> st_r == scp_pkg::SCP_RUN && sys_clk_r &&
        clock_running)
        else $error("held clock missed first source rise");

    c_direct_run: cover property (scp_pkg::scp_is_direct(act_r) &&
        $rose(sys_clk_r));
    c_presc_max: cover property (act_r.div == `SCP_DIV_MAX &&
        $fell(sys_clk_r));
    c_switch: cover property (go_hold && act_ok);
    c_hold_exit: cover property (start);

endmodule // scp_sysclk_gen

/* File: verilog/scp_defs.svh */
// Functional notes
// - select 11 feeds system clock straight from direct input, same frequency and duty
// - select 10 with vco bypass set runs prescaler mode, oscillator divided
// - prescaler input is crystal input or internal clock source
// - division factor equals prescaler divider field plus one
// - factor one passes oscillator clock unchanged, duty cycle preserved
// - division factor reaches 1024 for the lowest system clock
// - crystal bypass at factor one behaves like direct drive
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

`define SCP_DIV_W 10
`define SCP_SEL_DIRECT 2'h3
`define SCP_SEL_PRESC 2'h2
`define SCP_SEL_RST 2'h0
`define SCP_BYPASS_RST 1'h0
`define SCP_OSC_INT_RST 1'h0
`define SCP_DIV_RST 10'h000
`define SCP_DIV_ONE 10'h000
`define SCP_DIV_MAX 10'h3ff

`endif

/* File: verilog/scp_pkg.sv */
`include "scp_defs.svh"

package scp_pkg;

    typedef struct packed
    {
        logic [1:0] sel;
        logic bypass;
        logic osc_int;
        logic [`SCP_DIV_W-1:0] div;
    } scp_cfg_s;

    typedef enum logic [1:0]
    {
        SCP_RUN = 2'h0,
        SCP_HOLD = 2'h1
    } scp_state_e;

    function automatic logic scp_is_direct(input scp_cfg_s c);
        scp_is_direct = (c.sel == `SCP_SEL_DIRECT);
    endfunction

    function automatic logic scp_is_presc(input scp_cfg_s c);
        scp_is_presc = (c.sel == `SCP_SEL_PRESC) && c.bypass;
    endfunction

    // pll and wakeup selections are not built here; they park the clock low
    function automatic logic scp_cfg_valid(input scp_cfg_s c);
        scp_cfg_valid = scp_is_direct(c) || scp_is_presc(c);
    endfunction

    // direct drive has no divider in its path
    function automatic logic [`SCP_DIV_W-1:0] scp_eff_div(input scp_cfg_s c);
        scp_eff_div = scp_is_direct(c) ? `SCP_DIV_ONE : c.div;
    endfunction

endpackage

/* File: verilog/scp_src_tap.sv */
`include "scp_defs.svh"

module scp_src_tap
(
    input wire logic clock, // system sampling clock
    input wire logic rst, // async reset, active high
    input wire logic crystal_input, // crystal oscillator level
    input wire logic internal_clock_source, // on-chip oscillator level
    input wire logic direct_clock_input, // direct drive clock level
    input wire scp_pkg::scp_cfg_s cfg, // configuration in force
    output logic src_level, // selected source level
    output logic src_rise, // selected source rose this cycle
    output logic src_edge // selected source changed this cycle
);

    logic xtal_prev_r;
    logic int_prev_r;
    logic dir_prev_r;

    // every source keeps its own history so a source swap makes no fake edge
    wire osc_now = cfg.osc_int ? internal_clock_source : crystal_input;
    wire osc_prev = cfg.osc_int ? int_prev_r : xtal_prev_r;
    wire is_dir = scp_pkg::scp_is_direct(cfg);
    wire src_prev = is_dir ? dir_prev_r : osc_prev;

    assign src_level = is_dir ? direct_clock_input : osc_now;
    assign src_rise = src_level && !src_prev;
    assign src_edge = src_level != src_prev;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            xtal_prev_r <= 1'h0;
            int_prev_r <= 1'h0;
            dir_prev_r <= 1'h0;
        end
        else
        begin
            xtal_prev_r <= crystal_input;
            int_prev_r <= internal_clock_source;
            dir_prev_r <= direct_clock_input;
        end
    end

    a_src_direct: assert property (@(posedge clock) disable iff (rst)
        scp_pkg::scp_is_direct(cfg) |-> src_level == direct_clock_input)
        else $error("direct mode not fed from direct input");
    a_src_internal: assert property (@(posedge clock) disable iff (rst)
        scp_pkg::scp_is_presc(cfg) && cfg.osc_int
        |-> src_level == internal_clock_source)
        else $error("prescaler not fed from internal source");
    a_src_crystal: assert property (@(posedge clock) disable iff (rst)
        scp_pkg::scp_is_presc(cfg) && !cfg.osc_int
        |-> src_level == crystal_input)
        else $error("prescaler not fed from crystal");

endmodule // scp_src_tap

/* File: verif/tb_scp_sysclk_gen.sv */
`include "scp_defs.svh"

module tb_scp_sysclk_gen;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic crystal_input = 1'b0;
    logic internal_clock_source = 1'b0;
    logic direct_clock_input = 1'b0;
    logic [1:0] sel = 2'h0;
    logic byp = 1'b0;
    logic intl = 1'b0;
    logic [`SCP_DIV_W-1:0] div = 10'h000;
    logic sys_clk_out;
    scp_pkg::scp_cfg_s active_cfg;
    logic clock_running;
    logic [1:0] cnt = 2'h0;
    logic prev = 1'b0;
    logic mon_en = 1'b0;
    int run_len = 0;
    int min_len = 99999;
    int n_fail = 0;
    int n_checks = 0;

    scp_sysclk_gen uut
    (
        .clock(clock),
        .rst(rst),
        .crystal_input(crystal_input),
        .internal_clock_source(internal_clock_source),
        .direct_clock_input(direct_clock_input),
        .clock_source_select(sel),
        .vco_bypass(byp),
        .osc_source_internal(intl),
        .prescaler_divider_field(div),
        .sys_clk_out(sys_clk_out),
        .active_cfg(active_cfg),
        .clock_running(clock_running)
    );

    always #2 clock = ~clock;

    // three sources at distinct rates or duty cycles so a wrong mux shows as wrong phases
    always @(posedge clock)
    begin
        cnt <= cnt + 2'h1;
        crystal_input <= ~crystal_input;
        internal_clock_source <= cnt[1];
        direct_clock_input <= (cnt == 2'h0);
    end

    // the first partial phase after enabling is not counted
    always @(negedge clock)
    begin
        if (mon_en && sys_clk_out !== prev)
        begin
            if (run_len > 0 && run_len < min_len)
                min_len = run_len;
            run_len = 1;
        end
        else if (mon_en && run_len > 0)
            run_len = run_len + 1;
        prev = sys_clk_out;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cfg(input logic [1:0] s, input logic b, input logic i,
        input logic [9:0] d);
        @(posedge clock);
        sel <= s;
        byp <= b;
        intl <= i;
        div <= d;
    endtask

    // measures one full high and the following low phase, in clock cycles
    task automatic phases(input int hi, input int lo);
        int n;
        int h;
        int l;
        n = 0;
        h = 0;
        l = 0;
        @(negedge clock);
        while (sys_clk_out !== 1'b0 && n < 6000)
        begin
            @(negedge clock);
            n++;
        end
        while (sys_clk_out !== 1'b1 && n < 6000)
        begin
            @(negedge clock);
            n++;
        end
        while (sys_clk_out === 1'b1 && n < 6000)
        begin
            @(negedge clock);
            n++;
            h++;
        end
        while (sys_clk_out === 1'b0 && n < 6000)
        begin
            @(negedge clock);
            n++;
            l++;
        end
        check(h, hi);
        check(l, lo);
    endtask

    task automatic t_direct();
        cfg(2'h3, 1'b0, 1'b0, 10'h005);
        phases(1, 3);
        check(active_cfg.sel, 2'h3);
        check(clock_running, 1'b1);
        $display("test direct done");
    endtask

    task automatic t_presc();
        cfg(2'h2, 1'b1, 1'b0, 10'h000);
        phases(1, 1);
        cfg(2'h2, 1'b1, 1'b0, 10'h001);
        phases(2, 2);
        check(active_cfg, 14'h2801);
        cfg(2'h2, 1'b1, 1'b1, 10'h000);
        phases(2, 2);
        cfg(2'h2, 1'b1, 1'b1, 10'h002);
        phases(6, 6);
        $display("test prescaler done");
    endtask

    task automatic t_max();
        cfg(2'h2, 1'b1, 1'b0, 10'h3ff);
        phases(1024, 1024);
        $display("test max divider done");
    endtask

    task automatic t_off();
        cfg(2'h2, 1'b0, 1'b0, 10'h000);
        repeat (2100) @(posedge clock);
        @(negedge clock);
        check(clock_running, 1'b0);
        check(sys_clk_out, 1'b0);
        cfg(2'h1, 1'b0, 1'b0, 10'h000);
        repeat (5) @(posedge clock);
        @(negedge clock);
        check(clock_running, 1'b0);
        $display("test unbuilt mode done");
    endtask

    task automatic t_switch();
        cfg(2'h2, 1'b1, 1'b0, 10'h001);
        phases(2, 2);
        mon_en = 1'b1;
        repeat (7) @(posedge clock);
        cfg(2'h2, 1'b1, 1'b0, 10'h003);
        phases(4, 4);
        mon_en = 1'b0;
        // shortest legal half phase across a factor 2 to 4 switch is 2
        check(32'(min_len >= 2), 1);
        cfg(2'h3, 1'b0, 1'b0, 10'h003);
        phases(1, 3);
        $display("test switch done");
    endtask

    initial
    begin
        #240000;
        n_fail++;
        close_out();
    end

    initial
    begin
        repeat (5) @(posedge clock);
        check(active_cfg, 14'h0000);
        check(sys_clk_out, 1'b0);
        rst <= 1'b0;
        $display("test reset done");
        t_direct();
        t_presc();
        t_max();
        t_off();
        t_switch();
        close_out();
    end
endmodule // tb_scp_sysclk_gen
